// ### rtl/ocd_defs.vh
`ifndef OCD_DEFS_VH
`define OCD_DEFS_VH
// Register addresses on the plain port
`define OCD_ADDR_CONTROL   4'h0
`define OCD_ADDR_DIVISOR   4'h1
`define OCD_ADDR_UNLOCK    4'h2
`define OCD_ADDR_STATUS    4'h3
`define OCD_ADDR_MASK      4'h4
`define OCD_ADDR_ACTIVE    4'h5
// Control register fields
`define OCD_CTL_FAIL       3
`define OCD_CTL_SEC_EN     1
`define OCD_CTL_SWITCH     0
`define OCD_CTL_NEXT_LO    8
`define OCD_CTL_NEXT_HI    10
`define OCD_CTL_RESET      16'h0000
// Divisor register fields
`define OCD_DIV_RECOVER    15
`define OCD_DIV_RATIO_HI   14
`define OCD_DIV_RATIO_LO   12
`define OCD_DIV_SLOW_EN    11
`define OCD_DIV_RC_HI      10
`define OCD_DIV_RC_LO      8
`define OCD_DIV_POST_HI    7
`define OCD_DIV_POST_LO    6
`define OCD_DIV_PRE_HI     4
`define OCD_DIV_PRE_LO     0
`define OCD_DIV_RESET      16'h3040
`define OCD_DIV_WMASK      16'hFFDF
// Unlock keys, written back to back
`define OCD_KEY_FIRST      16'h0046
`define OCD_KEY_SECOND     16'h0057
// Interrupt status bits
`define OCD_EV_FAIL        0
`define OCD_EV_SWITCHED    1
// Fast RC source code
`define OCD_SRC_FAST_RC    3'h0
// Switch settle time in cycles
`define OCD_SWITCH_CYCLES  8
`endif

// ### rtl/ocd_sync.v
`timescale 1ns/1ps
module ocd_sync (
  input  wire clock,
  input  wire reset_n,
  input  wire din,
  output reg  dout
);
  reg stage;
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      stage <= 1'b0;
      dout  <= 1'b0;
    end else begin
      stage <= din;
      dout  <= stage;
    end
  end
endmodule // ocd_sync

// ### rtl/ocd_pow2_div.v
`timescale 1ns/1ps
// Emits a one-cycle enable every 2^shift cycles; shift 0 gives every cycle
module ocd_pow2_div #(
  parameter WIDTH = 8
) (
  input  wire       clock,
  input  wire       reset_n,
  input  wire [3:0] shift,
  output reg        tick
);
  reg  [WIDTH-1:0] count;
  wire [WIDTH-1:0] limit = (({{(WIDTH-1){1'b0}}, 1'b1}) << shift) - {{(WIDTH-1){1'b0}}, 1'b1};
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      count <= {WIDTH{1'b0}};
      tick  <= 1'b0;
    end else if (count >= limit) begin
      count <= {WIDTH{1'b0}};
      tick  <= 1'b1;
    end else begin
      count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
      tick  <= 1'b0;
    end
  end
endmodule // ocd_pow2_div

// ### rtl/ocd_osc_ctrl.v
// The placing of the registers and strobed register access were left to the implementer.
`timescale 1ns/1ps
`include "ocd_defs.vh"
// Notes on behaviour
// - A detected clock failure sets the fail flag, which holds until software clears it.
// - The secondary oscillator runs exactly while its enable bit is one.
// - Writing the switch request starts a switch to the next source; hardware clears it when done.
// - Control register writes are ignored unless the unlock keys came just before.
// - Both registers reset only on power-on reset, not on other resets.
// - Unimplemented bits read as zero.
// - Slowdown disabled forces 1:1; enabled, the ratio code picks a power-of-two divide.
// - The fast RC is divided by two to the power of the RC divide code.
// - With recovery set, any interrupt clears slowdown enable.
module ocd_osc_ctrl (
  input  wire        clock,
  input  wire        reset_n,
  input  wire        por_n,
  input  wire [3:0]  address,
  input  wire [15:0] write_data,
  input  wire        write_strobe,
  input  wire        read_strobe,
  output reg  [15:0] read_data,
  input  wire        fail_detect,
  input  wire        any_interrupt,
  output wire        secondary_osc_run,
  output reg  [2:0]  active_source,
  output reg         switch_busy,
  output wire        peripheral_tick,
  output wire        rc_tick,
  output reg  [2:0]  pll_output_divide_log2,
  output reg  [5:0]  pll_input_divide,
  output wire        irq
);
  ////////////////////////////////////////////////////////////////////////////
  reg  [15:0] control;
  reg  [15:0] divisor;
  reg  [1:0]  unlock_stage;
  reg  [1:0]  status;
  reg  [1:0]  mask;
  reg  [3:0]  settle;
  wire        fail_sync;
  reg         fail_seen;

  // Reset here is warm reset; control and divisor state follows only the power-on reset
  wire        hard_n = reset_n & por_n;

  ocd_sync u_fail_sync (
    .clock   (clock),
    .reset_n (hard_n),
    .din     (fail_detect),
    .dout    (fail_sync)
  );

  wire unlocked   = (unlock_stage == 2'h2);
  wire ctl_write  = write_strobe && (address == `OCD_ADDR_CONTROL);
  wire fail_rise  = fail_sync && !fail_seen;
  wire switch_done = switch_busy && (settle == 4'h0);
  // Settle load sized to the counter so no bits are dropped silently
  localparam [3:0] SETTLE_LOAD = `OCD_SWITCH_CYCLES - 1;

  ////////////////////////////////////////////////////////////////////////////
  // Unlock sequence, any other write breaks it
  always @(posedge clock or negedge hard_n) begin
    if (!hard_n) begin
      unlock_stage <= 2'h0;
    end else if (write_strobe) begin
      if (address == `OCD_ADDR_UNLOCK && write_data == `OCD_KEY_FIRST) begin
        unlock_stage <= 2'h1;
      end else if (address == `OCD_ADDR_UNLOCK && write_data == `OCD_KEY_SECOND
                   && unlock_stage == 2'h1) begin
        unlock_stage <= 2'h2;
      end else begin
        unlock_stage <= 2'h0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clock or negedge por_n) begin
    if (!por_n) begin
      control <= `OCD_CTL_RESET;
      divisor <= `OCD_DIV_RESET;
    end else begin
      if (ctl_write && unlocked) begin
        control[`OCD_CTL_NEXT_HI:`OCD_CTL_NEXT_LO] <=
          write_data[`OCD_CTL_NEXT_HI:`OCD_CTL_NEXT_LO];
        control[`OCD_CTL_SEC_EN] <= write_data[`OCD_CTL_SEC_EN];
        if (write_data[`OCD_CTL_SWITCH]) begin
          control[`OCD_CTL_SWITCH] <= 1'b1;
        end
        // Software may only clear the fail flag; a new failure wins
        if (!write_data[`OCD_CTL_FAIL] && !fail_rise) begin
          control[`OCD_CTL_FAIL] <= 1'b0;
        end
      end
      if (fail_rise) begin
        control[`OCD_CTL_FAIL] <= 1'b1;
      end
      if (switch_done) begin
        control[`OCD_CTL_SWITCH] <= 1'b0;
      end
      if (write_strobe && address == `OCD_ADDR_DIVISOR) begin
        divisor <= write_data & `OCD_DIV_WMASK;
      end
      if (divisor[`OCD_DIV_RECOVER] && any_interrupt) begin
        divisor[`OCD_DIV_SLOW_EN] <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Switch sequencer: takes the new source after a fixed settle time
  always @(posedge clock or negedge hard_n) begin
    if (!hard_n) begin
      switch_busy   <= 1'b0;
      settle        <= 4'h0;
      active_source <= `OCD_SRC_FAST_RC;
      fail_seen     <= 1'b0;
    end else begin
      fail_seen <= fail_sync;
      if (switch_done) begin
        switch_busy   <= 1'b0;
        active_source <= control[`OCD_CTL_NEXT_HI:`OCD_CTL_NEXT_LO];
      end else if (switch_busy) begin
        settle <= settle - 4'h1;
      end else if (control[`OCD_CTL_SWITCH]) begin
        // Illegal PLL-to-PLL hops are left to software to avoid
        switch_busy <= 1'b1;
        settle      <= SETTLE_LOAD;
      end
    end
  end

  assign secondary_osc_run = control[`OCD_CTL_SEC_EN];

  ////////////////////////////////////////////////////////////////////////////
  // Clock ratio enables
  wire [2:0] ratio = divisor[`OCD_DIV_RATIO_HI:`OCD_DIV_RATIO_LO];
  wire [3:0] peri_shift = divisor[`OCD_DIV_SLOW_EN] ? {1'b0, ratio} : 4'h0;
  wire [3:0] rc_shift   = {1'b0, divisor[`OCD_DIV_RC_HI:`OCD_DIV_RC_LO]};

  ocd_pow2_div #(.WIDTH(8)) u_peri_div (
    .clock   (clock),
    .reset_n (hard_n),
    .shift   (peri_shift),
    .tick    (peripheral_tick)
  );

  ocd_pow2_div #(.WIDTH(8)) u_rc_div (
    .clock   (clock),
    .reset_n (hard_n),
    .shift   (rc_shift),
    .tick    (rc_tick)
  );

  always @(posedge clock or negedge hard_n) begin
    if (!hard_n) begin
      pll_output_divide_log2 <= 3'h2;
      pll_input_divide       <= 6'h02;
    end else begin
      case (divisor[`OCD_DIV_POST_HI:`OCD_DIV_POST_LO])
        2'h0: pll_output_divide_log2 <= 3'h1;
        2'h1: pll_output_divide_log2 <= 3'h2;
        2'h3: pll_output_divide_log2 <= 3'h3;
        // Reserved code keeps the previous divide
        default: pll_output_divide_log2 <= pll_output_divide_log2;
      endcase
      pll_input_divide <= {1'b0, divisor[`OCD_DIV_PRE_HI:`OCD_DIV_PRE_LO]} + 6'h02;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status, write one to clear, set wins
  always @(posedge clock or negedge hard_n) begin
    if (!hard_n) begin
      status <= 2'h0;
      mask   <= 2'h0;
    end else begin
      if (write_strobe && address == `OCD_ADDR_MASK) begin
        mask <= write_data[1:0];
      end
      status[`OCD_EV_FAIL] <= fail_rise |
        (status[`OCD_EV_FAIL] & ~(write_strobe && address == `OCD_ADDR_STATUS
                                  && write_data[`OCD_EV_FAIL]));
      status[`OCD_EV_SWITCHED] <= switch_done |
        (status[`OCD_EV_SWITCHED] & ~(write_strobe && address == `OCD_ADDR_STATUS
                                      && write_data[`OCD_EV_SWITCHED]));
    end
  end

  assign irq = |(status & mask);

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clock or negedge hard_n) begin
    if (!hard_n) begin
      read_data <= 16'h0000;
    end else if (read_strobe) begin
      case (address)
        `OCD_ADDR_CONTROL: read_data <= control & 16'h070B;
        `OCD_ADDR_DIVISOR: read_data <= divisor;
        `OCD_ADDR_UNLOCK:  read_data <= {14'h0000, unlock_stage};
        `OCD_ADDR_STATUS:  read_data <= {14'h0000, status};
        `OCD_ADDR_MASK:    read_data <= {14'h0000, mask};
        `OCD_ADDR_ACTIVE:  read_data <= {12'h000, switch_busy, active_source};
        default:           read_data <= 16'h0000;
      endcase
    end else begin
      read_data <= 16'h0000;
    end
  end
endmodule // ocd_osc_ctrl

// ### verification/ocd_osc_ctrl_properties.sv
`timescale 1ns/1ps
`include "ocd_defs.vh"
module ocd_props (
  input logic        clock,
  input logic        reset_n,
  input logic        por_n,
  input logic [3:0]  address,
  input logic        read_strobe,
  input logic [15:0] read_data,
  input logic        secondary_osc_run,
  input logic [2:0]  active_source,
  input logic        switch_busy,
  input logic [2:0]  pll_output_divide_log2,
  input logic [5:0]  pll_input_divide,
  input logic        irq
);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n || !por_n);
  wire rd_ctl = read_strobe && address == `OCD_ADDR_CONTROL;
  wire rd_div = read_strobe && address == `OCD_ADDR_DIVISOR;
  AST_SEC: assert property (rd_ctl |=> read_data[1] == secondary_osc_run)
    else $error("sec run differs");
  AST_CTL_ZERO: assert property (rd_ctl |=> read_data[15:11] == 5'h00 && !read_data[2])
    else $error("ctl spare bits");
  AST_DIV_ZERO: assert property (rd_div |=> !read_data[5])
    else $error("div bit5");
  AST_UNMAP: assert property (read_strobe && address > 4'h5 |=> read_data == 16'h0000)
    else $error("unmapped read");
  // Busy must stay high for at least 7 cycles from its rise, then end within 3 cycles after that
  AST_BUSY: assert property ($rose(switch_busy) |-> switch_busy[*7] ##[1:3] !switch_busy)
    else $error("busy length");
  AST_SRC: assert property ($changed(active_source) |-> $past(switch_busy, 1) || $past(switch_busy, 2))
    else $error("source moved idle");
  AST_POST: assert property (pll_output_divide_log2 inside {3'h1, 3'h2, 3'h3})
    else $error("post divide");
  AST_PRE: assert property (pll_input_divide >= 6'h02 && pll_input_divide <= 6'h21)
    else $error("pre divide");
  cover property ($rose(switch_busy));
  cover property ($rose(irq));
  cover property (rd_div);
endmodule // ocd_props

bind ocd_osc_ctrl ocd_props u_props (
  .clock(clock), .reset_n(reset_n), .por_n(por_n), .address(address),
  .read_strobe(read_strobe), .read_data(read_data), .secondary_osc_run(secondary_osc_run),
  .active_source(active_source), .switch_busy(switch_busy), .irq(irq),
  .pll_output_divide_log2(pll_output_divide_log2), .pll_input_divide(pll_input_divide));

// ### verification/ocd_osc_ctrl_tb.sv
`timescale 1ns/1ps
`include "ocd_defs.vh"
module ocd_osc_ctrl_tb;
  logic        clock = 1'h0, reset_n = 1'h0, por_n = 1'h0, rd_seen = 1'h0;
  logic        write_strobe = 1'h0, read_strobe = 1'h0, fail_detect = 1'h0;
  logic        any_interrupt = 1'h0;
  logic [3:0]  address = 4'h0;
  logic [15:0] write_data = 16'h0000, read_data, e, q[$];
  logic [2:0]  active_source, pll_output_divide_log2, lg = 3'h2;
  logic [5:0]  pll_input_divide;
  logic        secondary_osc_run, switch_busy, peripheral_tick, rc_tick, irq;
  int          fail_count = 0, checks = 0, cyc = 0, i, n;
  always #50 clock = ~clock;
  ocd_osc_ctrl u_dut (
    .clock(clock), .reset_n(reset_n), .por_n(por_n), .address(address),
    .write_data(write_data), .write_strobe(write_strobe), .read_strobe(read_strobe),
    .read_data(read_data), .fail_detect(fail_detect), .any_interrupt(any_interrupt),
    .secondary_osc_run(secondary_osc_run), .active_source(active_source),
    .switch_busy(switch_busy), .peripheral_tick(peripheral_tick), .rc_tick(rc_tick),
    .pll_output_divide_log2(pll_output_divide_log2),
    .pll_input_divide(pll_input_divide), .irq(irq));
  ////////////////////////////////////////////////////////////////////////////////
  task chk(input logic [15:0] g, x);
    checks++;
    if (g !== x) begin
      fail_count++;
      $display("CHECK FAILED %0t got %h exp %h", $time, g, x);
    end
  endtask
  task wr(input logic [3:0] a, input logic [15:0] d);
    address <= a;
    write_data <= d;
    write_strobe <= 1'h1;
    read_strobe <= 1'h0;
    @(posedge clock);
  endtask
  task rd(input logic [3:0] a, input logic [15:0] x);
    q.push_back(x);
    address <= a;
    read_strobe <= 1'h1;
    write_strobe <= 1'h0;
    @(posedge clock);
  endtask
  task idle(input int c);
    write_strobe <= 1'h0;
    read_strobe <= 1'h0;
    repeat (c) @(posedge clock);
  endtask
  task unl;
    wr(`OCD_ADDR_UNLOCK, `OCD_KEY_FIRST);
    wr(`OCD_ADDR_UNLOCK, `OCD_KEY_SECOND);
  endtask
  // Cycles until the chosen signal is seen high, or for 3 until switch_busy is seen low; bounded so a stuck output cannot hang
  task wt(input int s);
    n = 1;
    @(posedge clock);
    while ((s == 0 ? peripheral_tick : s == 1 ? rc_tick : s == 2 ? switch_busy
            : !switch_busy) !== 1'h1 && n < 300) begin
      @(posedge clock);
      n++;
    end
  endtask
  task test_done;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge clock) begin
    if (rd_seen) chk(read_data, q.pop_front());
    rd_seen <= read_strobe;
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      test_done;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(33861));
    repeat (16) @(posedge clock);
    reset_n <= 1'h1;
    por_n <= 1'h1;
    @(posedge clock);
    rd(`OCD_ADDR_CONTROL, `OCD_CTL_RESET);
    rd(`OCD_ADDR_DIVISOR, `OCD_DIV_RESET);
    wr(4'h9, 16'hFFFF);
    rd(4'h9, 16'h0000);
    wr(`OCD_ADDR_CONTROL, 16'h0002);
    wr(`OCD_ADDR_UNLOCK, `OCD_KEY_SECOND);
    wr(`OCD_ADDR_UNLOCK, `OCD_KEY_FIRST);
    wr(`OCD_ADDR_CONTROL, 16'h0002);
    rd(`OCD_ADDR_CONTROL, 16'h0000);
    unl;
    wr(`OCD_ADDR_CONTROL, 16'h0002);
    rd(`OCD_ADDR_CONTROL, 16'h0002);
    idle(1);
    chk(secondary_osc_run, 1'h1);
    $display("lock test done");
    wr(`OCD_ADDR_MASK, 16'h0003);
    unl;
    wr(`OCD_ADDR_CONTROL, 16'h0203);
    idle(0);
    wt(2);
    wt(3);
    chk(n[15:0], `OCD_SWITCH_CYCLES);
    idle(2);
    chk(active_source, 3'h2);
    rd(`OCD_ADDR_CONTROL, 16'h0202);
    rd(`OCD_ADDR_STATUS, 16'h0002);
    idle(1);
    chk(irq, 1'h1);
    wr(`OCD_ADDR_STATUS, 16'h0003);
    wr(`OCD_ADDR_MASK, 16'h0000);
    fail_detect <= 1'h1;
    idle(6);
    fail_detect <= 1'h0;
    chk(irq, 1'h0);
    rd(`OCD_ADDR_CONTROL, 16'h020A);
    rd(`OCD_ADDR_STATUS, 16'h0001);
    wr(`OCD_ADDR_MASK, 16'h0001);
    idle(2);
    chk(irq, 1'h1);
    wr(`OCD_ADDR_STATUS, 16'h0001);
    rd(`OCD_ADDR_CONTROL, 16'h020A);
    idle(1);
    chk(irq, 1'h0);
    unl;
    wr(`OCD_ADDR_CONTROL, 16'h0202);
    idle(1);
    reset_n <= 1'h0;
    idle(3);
    reset_n <= 1'h1;
    idle(1);
    rd(`OCD_ADDR_CONTROL, 16'h0202);
    $display("switch test done");
    // Every ratio and RC divide code once in passes 0-7, random postscaler; the last pass has slowdown off
    for (i = 0; i < 9; i++) begin
      e = $urandom & 16'h00DF;
      e[14:8] = {(i < 8) ? i[2:0] : 3'h6, i < 8, ~i[2:0]};
      if (e[7:6] != 2'h2) lg = (e[7:6] == 2'h3) ? 3'h3 : {1'h0, e[7:6]} + 3'h1;
      wr(`OCD_ADDR_DIVISOR, e);
      rd(`OCD_ADDR_DIVISOR, e);
      idle(2);
      chk(pll_output_divide_log2, lg);
      chk(pll_input_divide, e[4:0] + 6'h02);
      repeat (3) wt(0);
      chk(n[15:0], 16'(1 << ((i < 8) ? i : 0)));
      repeat (3) wt(1);
      chk(n[15:0], 16'(1 << ~i[2:0]));
    end
    wr(`OCD_ADDR_DIVISOR, 16'hB800);
    idle(1);
    any_interrupt <= 1'h1;
    idle(1);
    any_interrupt <= 1'h0;
    rd(`OCD_ADDR_DIVISOR, 16'hB000);
    idle(3);
    $display("divisor test done");
    test_done;
  end
endmodule // ocd_osc_ctrl_tb
